// >>> hw/boot_glue_map.svh
// constants for the boot memory select glue
`ifndef BOOT_GLUE_MAP_SVH
`define BOOT_GLUE_MAP_SVH

`define MODE_SERIAL_MASTER 3'h0
`define MODE_PAR_UP 3'h2
`define MODE_PAR_DOWN 3'h3
`define UPPER_ADDR_W 5
`define UPPER_ADDR_ZEROS 5'h00
`define UPPER_ADDR_ONES 5'h1f
`define TOP_ADDR_BIT 4

`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define CTRL_PROG_BIT 0
`define CTRL_IO32_DRV_BIT 1
`define CTRL_IO32_VAL_BIT 2
`define CTRL_RESET 3'h0
`define CTRL_W 3
`define STAT_W 8
`define RDATA_RESET 32'h00000000
`define WDT_RESET 1'b1

`endif

// >>> hw/boot_glue_pkg.sv
// types for the boot memory select glue
package boot_glue_pkg;

	typedef enum logic [1:0] {
		boot_serial,
		boot_par_up,
		boot_par_down,
		boot_other
	} boot_kind_t;

	typedef struct packed {
		logic [4:0] out;
		logic [4:0] oe;
	} addr_drive_t;

	typedef struct packed {
		logic prog_req;
		logic io32_drive;
		logic io32_value;
	} ctrl_t;

endpackage

// >>> hw/boot_memory_select_glue.sv
// boot memory select glue with apb control and status
`timescale 1ns/1ns
`include "boot_glue_map.svh"

// Contract
// - serial master mode enables serial memory
// - other modes keep serial memory disabled
// - upward parallel, not finished: address zeros
// - downward parallel, not finished: address ones
// - otherwise upper address lines released
// - reprogram request drives low or floats
// - watchdog enable reads jumper, default high
// - top address line shared with expansion
module boot_memory_select_glue
	import boot_glue_pkg::*;
(
	input wire logic core_clk, // clock, 20 MHz
	input wire logic reset, // sync reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [2:0] config_mode, // main chip mode pins
	input wire logic config_finished_in, // main chip finished pin
	input wire logic watchdog_enable_in, // jumper level, pulled high
	output logic serial_boot_en_n, // serial memory enable, low
	output logic [4:0] flash_addr_upper_out, // upper address out
	output logic [4:0] flash_addr_upper_oe, // upper address enable
	output logic reprogram_request_n_out, // reprogram pin out
	output logic reprogram_request_n_oe, // reprogram pin enable
	output logic watchdog_enable // registered jumper level
);

	////////////////////////////////////////////////////////////////
	boot_kind_t kind;
	addr_drive_t drive;
	ctrl_t ctrl_r, ctrl_nxt;
	logic [31:0] rdata_nxt;
	logic [31:0] prdata_r;
	logic wdt_r, wdt_nxt;
	logic sel_ctrl, sel_stat, mapped, wr_en;
	logic par_active;

	boot_mode_decode u_decode (
		.mode(config_mode),
		.finished(config_finished_in),
		.kind(kind),
		.drive(drive)
	);

	////////////////////////////////////////////////////////////////
	// pins are combinational: boot must not wait for a clock
	always_comb begin
		serial_boot_en_n = (kind == boot_serial) ? 1'b0 : 1'b1;
	end

	// expansion drive yields during parallel boot
	always_comb begin
		flash_addr_upper_out = drive.out;
		flash_addr_upper_oe = drive.oe;
		if (drive.oe == `UPPER_ADDR_ZEROS && ctrl_r.io32_drive) begin
			flash_addr_upper_oe[`TOP_ADDR_BIT] = 1'b1;
			flash_addr_upper_out[`TOP_ADDR_BIT] = ctrl_r.io32_value;
		end
	end

	always_comb begin
		reprogram_request_n_out = 1'b0;
		reprogram_request_n_oe = ctrl_r.prog_req;
	end

	////////////////////////////////////////////////////////////////
	// apb slave, zero wait states
	always_comb begin
		sel_ctrl = (paddr == `REG_CTRL);
		sel_stat = (paddr == `REG_STATUS);
		mapped = sel_ctrl | sel_stat;
		wr_en = psel & penable & pwrite & sel_ctrl;
		pready = 1'b1;
		pslverr = psel & penable & ~mapped;
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (wr_en) begin
			ctrl_nxt.prog_req = pwdata[`CTRL_PROG_BIT];
			ctrl_nxt.io32_drive = pwdata[`CTRL_IO32_DRV_BIT];
			ctrl_nxt.io32_value = pwdata[`CTRL_IO32_VAL_BIT];
		end
		wdt_nxt = watchdog_enable_in;
		rdata_nxt = prdata_r;
		if (psel && !penable && !pwrite) begin
			rdata_nxt = `RDATA_RESET;
			if (sel_ctrl)
				rdata_nxt[`CTRL_W-1:0] = {ctrl_r.io32_value,
					ctrl_r.io32_drive, ctrl_r.prog_req};
			else if (sel_stat)
				rdata_nxt[`STAT_W-1:0] = {wdt_r, config_finished_in,
					config_mode, kind, serial_boot_en_n};
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_r <= ctrl_t'(`CTRL_RESET);
			wdt_r <= `WDT_RESET;
			prdata_r <= `RDATA_RESET;
		end else begin
			ctrl_r <= ctrl_nxt;
			wdt_r <= wdt_nxt;
			prdata_r <= rdata_nxt;
		end
	end

	assign prdata = prdata_r;
	assign watchdog_enable = wdt_r;

	////////////////////////////////////////////////////////////////
	sequence par_boot_s;
		(config_mode == `MODE_PAR_UP || config_mode == `MODE_PAR_DOWN)
			&& !config_finished_in;
	endsequence

	serial_en_a: assert property (@(posedge core_clk) disable iff (reset)
		config_mode == `MODE_SERIAL_MASTER |-> !serial_boot_en_n)
		else $error("serial memory not enabled");
	serial_off_a: assert property (@(posedge core_clk) disable iff (reset)
		config_mode != `MODE_SERIAL_MASTER |-> serial_boot_en_n)
		else $error("serial memory enabled wrongly");
	up_zeros_a: assert property (@(posedge core_clk) disable iff (reset)
		config_mode == `MODE_PAR_UP && !config_finished_in |->
		flash_addr_upper_oe == `UPPER_ADDR_ONES &&
		flash_addr_upper_out == `UPPER_ADDR_ZEROS)
		else $error("upward address not zeros");
	down_ones_a: assert property (@(posedge core_clk) disable iff (reset)
		config_mode == `MODE_PAR_DOWN && !config_finished_in |->
		flash_addr_upper_oe == `UPPER_ADDR_ONES &&
		flash_addr_upper_out == `UPPER_ADDR_ONES)
		else $error("downward address not ones");
	addr_release_a: assert property (@(posedge core_clk) disable iff (reset)
		!(config_mode == `MODE_PAR_UP || config_mode == `MODE_PAR_DOWN)
		|| config_finished_in |->
		flash_addr_upper_oe[`TOP_ADDR_BIT-1:0] == '0)
		else $error("address lines not released");
	prog_low_a: assert property (@(posedge core_clk) disable iff (reset)
		reprogram_request_n_oe |-> !reprogram_request_n_out)
		else $error("reprogram driven high");
	wdt_follow_a: assert property (@(posedge core_clk) disable iff (reset)
		1'b1 |=> watchdog_enable == $past(watchdog_enable_in))
		else $error("watchdog enable not following jumper");
	io32_yield_a: assert property (@(posedge core_clk) disable iff (reset)
		par_boot_s |-> flash_addr_upper_out[`TOP_ADDR_BIT] ==
		(config_mode == `MODE_PAR_DOWN))
		else $error("top address contended");

	////////////////////////////////////////////////////////////////
	// control path checks: a stray bus access must never pull the
	// main chip's reprogram pin or grab the shared top line
	assign par_active = (config_mode == `MODE_PAR_UP ||
		config_mode == `MODE_PAR_DOWN) && !config_finished_in;

	sequence ctrl_write_s;
		psel && penable && pwrite && paddr == `REG_CTRL;
	endsequence

	sequence read_setup_s;
		psel && !penable && !pwrite;
	endsequence

	sequence stray_access_s;
		psel && penable && paddr != `REG_CTRL && paddr != `REG_STATUS;
	endsequence

	prog_write_a: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_write_s |=>
		reprogram_request_n_oe == $past(pwdata[`CTRL_PROG_BIT]))
		else $error("reprogram request not written");
	prog_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		!(psel && penable && pwrite && paddr == `REG_CTRL) |=>
		$stable(reprogram_request_n_oe))
		else $error("reprogram request changed without write");
	stray_err_a: assert property (@(posedge core_clk) disable iff (reset)
		stray_access_s |-> pslverr)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (@(posedge core_clk) disable iff (reset)
		psel && (paddr == `REG_CTRL || paddr == `REG_STATUS) |->
		pready && !pslverr)
		else $error("mapped access refused");
	stat_write_a: assert property (@(posedge core_clk) disable iff (reset)
		psel && penable && pwrite && paddr == `REG_STATUS |=>
		$stable(ctrl_r))
		else $error("status write changed control");

	ctrl_read_a: assert property (@(posedge core_clk) disable iff (reset)
		read_setup_s ##0 (paddr == `REG_CTRL) |=>
		prdata[`CTRL_W-1:0] == $past({ctrl_r.io32_value,
		ctrl_r.io32_drive, reprogram_request_n_oe}))
		else $error("control read back wrong");
	stat_read_a: assert property (@(posedge core_clk) disable iff (reset)
		read_setup_s ##0 (paddr == `REG_STATUS) |=>
		prdata[`STAT_W-1:0] == $past({watchdog_enable,
		config_finished_in, config_mode, kind, serial_boot_en_n}))
		else $error("status read back wrong");

	io32_drive_a: assert property (@(posedge core_clk) disable iff (reset)
		ctrl_r.io32_drive && !par_active |->
		flash_addr_upper_oe[`TOP_ADDR_BIT] &&
		flash_addr_upper_out[`TOP_ADDR_BIT] == ctrl_r.io32_value)
		else $error("expansion line not driven");
	all_release_a: assert property (@(posedge core_clk) disable iff (reset)
		!ctrl_r.io32_drive && !par_active |->
		flash_addr_upper_oe == `UPPER_ADDR_ZEROS)
		else $error("released lines still driven");

	// reset itself is the antecedent, so no disable here
	reset_vals_a: assert property (@(posedge core_clk)
		reset |=> !reprogram_request_n_oe && watchdog_enable &&
		prdata == `RDATA_RESET)
		else $error("reset values wrong");

endmodule

// >>> hw/boot_mode_decode.sv
// configuration mode decode into boot kind and upper address drive
`timescale 1ns/1ns
`include "boot_glue_map.svh"

module boot_mode_decode
	import boot_glue_pkg::*;
(
	input wire logic [2:0] mode, // configuration mode pins
	input wire logic finished, // configuration finished pin
	output boot_kind_t kind, // decoded boot kind
	output addr_drive_t drive // upper address lines drive
);

	always_comb begin
		case (mode)
			`MODE_SERIAL_MASTER: kind = boot_serial;
			`MODE_PAR_UP: kind = boot_par_up;
			`MODE_PAR_DOWN: kind = boot_par_down;
			default: kind = boot_other;
		endcase
	end

	always_comb begin
		drive.out = `UPPER_ADDR_ZEROS;
		drive.oe = `UPPER_ADDR_ZEROS;
		if (kind == boot_par_up && !finished) begin
			drive.out = `UPPER_ADDR_ZEROS;
			drive.oe = `UPPER_ADDR_ONES;
		end
		else if (kind == boot_par_down && !finished) begin
			drive.out = `UPPER_ADDR_ONES;
			drive.oe = `UPPER_ADDR_ONES;
		end
	end

endmodule

// >>> test/boot_board_model.sv
// board side of the boot pins: wire levels and jumper
`timescale 1ns/1ns
module boot_board_model (
	input wire logic core_clk, // clock
	input wire logic [4:0] a_out, // upper address out
	input wire logic [4:0] a_oe, // upper address enable
	input wire logic p_out, // reprogram out
	input wire logic p_oe, // reprogram enable
	input wire logic fit, // jumper fitted
	input wire logic lvl, // jumper level
	output logic [4:0] a_line, // address line level
	output logic p_pin, // reprogram pin level
	output logic wd_in, // jumper pin level
	output logic io32 // expansion io 32 net level
);
	logic flip = 1'b0;
	always @(posedge core_clk) flip <= ~flip;
	always_comb for (int i = 0; i < 5; i++) a_line[i] = a_oe[i] ? a_out[i] : flip;
	assign p_pin = p_oe ? p_out : 1'b1;
	assign wd_in = fit ? lvl : 1'b1;
	// top line is io 32; flash decodes below it
	assign io32 = a_line[4];
endmodule

// >>> test/boot_memory_select_glue_tb_top.sv
// bench for the boot memory select glue
`timescale 1ns/1ns
module boot_memory_select_glue_tb_top;
	import boot_glue_pkg::*;
	logic core_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
	logic fin = 0, fit = 0, lvl = 0, pready, pslverr, err, sen_n, wde;
	logic p_out, p_oe, p_pin, wd_in, io32, io_d = 0, io_v = 0;
	logic [2:0] mode = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [4:0] a_out, a_oe, a_line;
	logic [15:0] lf = 16'haff5;
	int n_fail = 0, n_checks = 0;
	always #25 core_clk = ~core_clk;
	boot_memory_select_glue boot_memory_select_glue_inst (.core_clk, .reset,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.config_mode(mode), .config_finished_in(fin), .watchdog_enable_in(wd_in),
		.serial_boot_en_n(sen_n), .flash_addr_upper_out(a_out),
		.flash_addr_upper_oe(a_oe), .reprogram_request_n_out(p_out),
		.reprogram_request_n_oe(p_oe), .watchdog_enable(wde));
	boot_board_model boot_board_model_inst (.core_clk, .a_out, .a_oe, .p_out,
		.p_oe, .fit, .lvl, .a_line, .p_pin, .wd_in, .io32);
	////////////////////////////////////////////////////////////////////////
	function logic [10:0] exp_pins(logic [2:0] m, logic f, logic d, logic v);
		logic par;
		logic [4:0] oe, val;
		par = !f && (m == 3'h2 || m == 3'h3);
		oe = par ? 5'h1f : {d, 4'h0};
		val = par ? (m[0] ? 5'h1f : 5'h00) : {d & v, 4'h0};
		return {m != 3'h0, oe, val};
	endfunction
	function logic [15:0] lfsr(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task pins(input logic [2:0] m, input logic f);
		mode <= m;
		fin <= f;
		@(posedge core_clk);
		@(posedge core_clk);
		chk({sen_n, a_oe, a_line & a_oe}, exp_pins(m, f, io_d, io_v));
	endtask
	task end_of_test;
		if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_fail++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge core_clk);
		reset <= 0;
		repeat (2) @(posedge core_clk);
		chk(wde, 1);
		fit <= 1;
		repeat (3) @(posedge core_clk);
		chk(wde, 0);
		apb(1, 12'h000, 32'h7);
		{io_v, io_d} = 2'b11;
		apb(0, 12'h000, 32'h0);
		chk(rd, 32'h7);
		pins(3'h0, 0);
		chk(p_pin, 0);
		chk({a_oe[4], io32}, 2'b11);
		pins(3'h2, 0);
		chk({a_oe[4], io32}, 2'b10);
		apb(0, 12'h004, 32'h0);
		chk(rd, 32'h13);
		apb(0, 12'h008, 32'h0);
		chk(err, 1);
		chk(rd, 0);
		apb(1, 12'h000, 32'h0);
		{io_v, io_d} = 2'b00;
		@(posedge core_clk);
		chk(p_pin, 1);
		apb(1, 12'h008, 32'h1);
		chk(err, 1);
		@(posedge core_clk);
		chk(p_pin, 1);
		for (int i = 0; i < 16; i++) pins(i[2:0], i[3]);
		repeat (200) begin
			lf = lfsr(lf);
			pins(lf[2:0], lf[3]);
		end
		end_of_test;
	end
endmodule
